// file: hw/vsc_dimmer.sv
// Grid multiplexer with digital dimming duty for the anode drivers.
`timescale 1ns/1ps
module vsc_dimmer #(
    parameter int BIT_DIV = vsc_pkg::BIT_DIV
) (
    input wire logic clk,
    input wire logic rst_b,
    vsc_disp_if.drive disp
);
    typedef struct packed {
        logic [15:0] div;
        logic [9:0] pwm;
        logic [1:0] grid;
        logic [31:0] anode;
        logic [2:0] cathode;
    } vsc_dim_type;

    vsc_dim_type st;
    vsc_dim_type next_st;
    logic tick;
    logic lit;
    logic [9:0] duty;
    logic [1:0] last_grid;

    always_comb begin
        next_st = st;
        tick = (st.div == 16'(BIT_DIV - 1));
        last_grid = disp.triplex ? 2'h2 : 2'h1;
        if (disp.duty >= vsc_pkg::DIM_LIMIT) begin // see R18
            duty = vsc_pkg::DIM_LIMIT;
        end else begin
            duty = disp.duty;
        end
        lit = (st.pwm < duty); // see R18
        next_st.div = tick ? 16'h0000 : st.div + 16'h0001;
        if (tick) begin
            next_st.pwm = st.pwm + 10'h001;
            if (st.pwm == vsc_pkg::PWM_LAST) begin
                next_st.grid = (st.grid >= last_grid) ? 2'h0 :
                    st.grid + 2'h1;
            end
        end
        if (lit) begin
            next_st.anode = disp.pattern[st.grid]; // see R16
            next_st.cathode = ~(3'h1 << st.grid);
        end else begin
            next_st.anode = 32'h00000000;
            next_st.cathode = vsc_pkg::CATHODE_OFF;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
            st.cathode <= vsc_pkg::CATHODE_OFF; // see R3
        end else begin
            st <= next_st;
        end
    end

    assign disp.anode = st.anode;
    assign disp.cathode = st.cathode;
endmodule : vsc_dimmer

// file: hw/vsc_disp_if.sv
// Display data passed from the command port to the dimming driver.
`timescale 1ns/1ps
interface vsc_disp_if;
    logic [2:0][31:0] pattern;
    logic [9:0] duty;
    logic triplex;
    logic [31:0] anode;
    logic [2:0] cathode;

    modport ctrl (output pattern, output duty, output triplex,
        input anode, input cathode);
    modport drive (input pattern, input duty, input triplex,
        output anode, output cathode);
endinterface : vsc_disp_if

// file: hw/vsc_pin_sync.sv
// Two flip-flop synchroniser for asynchronous pin inputs.
`timescale 1ns/1ps
module vsc_pin_sync #(
    parameter int W = 3
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } vsc_sync_type;

    vsc_sync_type st;
    vsc_sync_type next_st;

    always_comb begin
        next_st.s1 = d;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.s2;
endmodule : vsc_pin_sync

// file: hw/vsc_pkg.sv
// Shared constants for the serial command port of the display driver.
package vsc_pkg;

    // Frame geometry.
    localparam int FRAME_W = 64;
    localparam int CODE_W = 3;
    localparam int SEG_W = 32;
    localparam int DIM_W = 10;
    localparam int GRIDS = 3;
    localparam int KEY_W = 37;
    localparam int KEY_MATRIX_W = 25;
    localparam int KNOBS = 3;
    localparam int KNOB_CNT_W = 3;
    localparam int ADC_W = 64;
    localparam int CNT_W = 7;

    // Field positions inside the receive shift register, newest bit at 0.
    localparam int CODE_POS = 0;
    localparam int SEG_POS = 3;
    localparam int DIM_POS = 3;

    // Function codes, value = m0 + 2*m1 + 4*m2.
    localparam logic [2:0] FN_ALL = 3'h0;
    localparam logic [2:0] FN_G1 = 3'h1;
    localparam logic [2:0] FN_G2 = 3'h2;
    localparam logic [2:0] FN_G3 = 3'h3;
    localparam logic [2:0] FN_DIM = 3'h4;
    localparam logic [2:0] FN_STOP = 3'h5;
    localparam logic [2:0] FN_KEYS = 3'h6;
    localparam logic [2:0] FN_ADC = 3'h7;

    // Dimming limits and reset values.
    localparam logic [9:0] DIM_LIMIT = 10'h3f8;
    localparam logic [9:0] DIM_RESET = 10'h000;
    localparam logic [9:0] PWM_LAST = 10'h3ff;
    localparam logic [2:0] CATHODE_OFF = 3'h7;
    localparam int BIT_DIV = 4;

    // Register map, byte addresses on the APB.
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CONFIG = 8'h04;
    localparam logic [7:0] ADDR_PAT1 = 8'h08;
    localparam logic [7:0] ADDR_PAT2 = 8'h0c;
    localparam logic [7:0] ADDR_PAT3 = 8'h10;
    localparam int CFG_TRIPLEX = 0;
    localparam int CFG_SCAN_START = 1;
    localparam logic CFG_TRIPLEX_RESET = 1'b1;
    localparam int ST_RUN = 10;
    localparam int ST_ALERT = 11;
    localparam int ST_ARMED = 12;
    localparam int ST_SEND = 13;
    localparam int ST_OE = 14;

endpackage : vsc_pkg

// file: hw/vsc_port.sv
// Serial command port with APB status access for the display driver.
//
// Functional notes
// R1: Reset clears every shift register and data latch to zero.
// R2: Reset sets the dimming duty to zero.
// R3: After reset anodes low, cathodes high, scan lines low, alert low.
// R4: Serial bits count only while select is high.
// R5: Data bits are sampled on each rising serial clock edge.
// R6: Select falling moves the frame into the latch chosen by the code.
// R7: Host sends the function code right after the payload in one frame.
// R8: Readout bits leave the shift register on rising serial clock edges.
// R9: Host sends readout code, toggles select, then clocks data out.
// R10: Select falling after a readout returns the data line to input.
// R11: A lone key scan stop code halts scanning at once.
// R12: Codes decode to all grids, grid 1, 2, dimming, stop, keys.
// R13: Code with bits 0 and 1 set loads only grid 3.
// R14: Code zero copies the pattern into all three grid latches.
// R15: Codes one to three load only the selected grid latch.
// R16: Segment frame is 35 bits; pattern bit n drives anode n high.
// R17: Dimming frame is 13 bits, value least significant bit first.
// R18: Grid duty is value over 1024, capped at 1016 over 1024.
// R19: Code seven reads out the eight 8-bit converter results.
// R20: A readout code turns the data line into an output.
// R21: The code is the last three bits shifted before select falls.
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module vsc_port #(
    parameter int BIT_DIV = vsc_pkg::BIT_DIV
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ser_clk,
    input wire logic ser_sel,
    input wire logic ser_data_in,
    output logic ser_data_out,
    output logic ser_data_oe,
    input wire logic [24:0] key_matrix_bits,
    input wire logic [2:0] knob_direction_bit,
    input wire logic [8:0] knob_count_bits,
    input wire logic [63:0] converter_result_bits,
    input wire logic key_change,
    input wire logic scan_done,
    output logic keyscan_run,
    output logic host_alert,
    output logic [31:0] anode_outputs,
    output logic [2:0] cathode_drives
);
    typedef enum logic [1:0] {
        LS_RECV,
        LS_ARMED,
        LS_SEND
    } vsc_link_state_type;

    typedef struct packed {
        logic clk_prev;
        logic sel_prev;
        logic [63:0] sr;
        logic [6:0] nbits;
        logic [2:0][31:0] pattern;
        logic [9:0] duty;
        logic run;
        logic alert;
        vsc_link_state_type ls;
        logic keys;
        logic [63:0] osr;
        logic dout;
        logic oe;
        logic triplex;
        logic [31:0] prdata;
        logic pslverr;
    } vsc_port_type;

    vsc_port_type st;
    vsc_port_type next_st;
    vsc_disp_if disp ();

    logic [2:0] pins_sync;
    logic s_clk;
    logic s_sel;
    logic s_din;
    logic clk_rise;
    logic sel_fall;
    logic sel_rise;
    logic [2:0] code;
    logic [31:0] seg;
    logic [9:0] dim;
    logic [36:0] key_report;
    logic setup;
    logic access;
    logic alert_clear;

    function automatic logic [2:0] frame_code(input logic [63:0] sr);
        frame_code = {sr[vsc_pkg::CODE_POS],
            sr[vsc_pkg::CODE_POS + 1],
            sr[vsc_pkg::CODE_POS + 2]};
    endfunction : frame_code

    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a == vsc_pkg::ADDR_STATUS) ||
            (a == vsc_pkg::ADDR_CONFIG) || (a == vsc_pkg::ADDR_PAT1) ||
            (a == vsc_pkg::ADDR_PAT2) || (a == vsc_pkg::ADDR_PAT3);
    endfunction : addr_mapped

    vsc_pin_sync #(
        .W(3)
    ) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d({ser_clk, ser_sel, ser_data_in}),
        .q(pins_sync)
    );

    vsc_dimmer #(
        .BIT_DIV(BIT_DIV)
    ) u_dimmer (
        .clk(clk),
        .rst_b(rst_b),
        .disp(disp.drive)
    );

    assign s_clk = pins_sync[2];
    assign s_sel = pins_sync[1];
    assign s_din = pins_sync[0];

    // Pattern and dimming value unpacked from the frame; key report built from the key and knob inputs.
    always_comb begin
        code = frame_code(st.sr); // see R21
        for (int k = 0; k < vsc_pkg::SEG_W; k++) begin
            seg[k] = st.sr[vsc_pkg::SEG_POS + vsc_pkg::SEG_W - 1 - k];
        end
        for (int k = 0; k < vsc_pkg::DIM_W; k++) begin
            dim[k] = st.sr[vsc_pkg::DIM_POS + vsc_pkg::DIM_W - 1 - k];
        end
        key_report = '0;
        key_report[24:0] = key_matrix_bits;
        for (int k = 0; k < vsc_pkg::KNOBS; k++) begin
            key_report[25 + 4 * k] = knob_direction_bit[k];
            key_report[26 + 4 * k] = knob_count_bits[3 * k];
            key_report[27 + 4 * k] = knob_count_bits[3 * k + 1];
            key_report[28 + 4 * k] = knob_count_bits[3 * k + 2];
        end
    end

    always_comb begin
        next_st = st;
        clk_rise = s_clk & ~st.clk_prev;
        sel_fall = ~s_sel & st.sel_prev;
        sel_rise = s_sel & ~st.sel_prev;
        setup = psel & ~penable;
        access = psel & penable;
        alert_clear = 1'b0;
        next_st.clk_prev = s_clk;
        next_st.sel_prev = s_sel;
        unique case (st.ls)
            LS_RECV: begin
                if (s_sel && clk_rise) begin // see R4
                    next_st.sr = {st.sr[62:0], s_din}; // see R5
                    if (st.nbits != 7'h7f) begin
                        next_st.nbits = st.nbits + 7'h01;
                    end
                end
                if (sel_fall) begin
                    next_st.nbits = 7'h00;
                    if (st.nbits >= 7'(vsc_pkg::CODE_W)) begin // see R6
                        unique case (code) // see R12
                            vsc_pkg::FN_ALL: begin
                                for (int g = 0; g < vsc_pkg::GRIDS; g++) begin
                                    next_st.pattern[g] = seg; // see R14
                                end
                            end
                            vsc_pkg::FN_G1: begin
                                next_st.pattern[0] = seg; // see R15
                            end
                            vsc_pkg::FN_G2: begin
                                next_st.pattern[1] = seg; // see R15
                            end
                            vsc_pkg::FN_G3: begin
                                next_st.pattern[2] = seg; // see R13
                            end
                            vsc_pkg::FN_DIM: begin
                                next_st.duty = dim; // see R17
                            end
                            vsc_pkg::FN_STOP: begin
                                next_st.run = 1'b0; // see R11
                            end
                            vsc_pkg::FN_KEYS: begin
                                next_st.ls = LS_ARMED;
                                next_st.keys = 1'b1;
                                next_st.oe = 1'b1; // see R20
                                alert_clear = 1'b1;
                            end
                            vsc_pkg::FN_ADC: begin
                                next_st.ls = LS_ARMED; // see R19
                                next_st.keys = 1'b0;
                                next_st.oe = 1'b1; // see R20
                            end
                        endcase
                    end
                end
            end
            LS_ARMED: begin
                if (sel_rise) begin
                    next_st.ls = LS_SEND;
                    if (st.keys) begin
                        next_st.osr = {27'h0000000, key_report};
                    end else begin
                        next_st.osr = converter_result_bits; // see R19
                    end
                end
            end
            LS_SEND: begin
                if (s_sel && clk_rise) begin
                    next_st.dout = st.osr[0]; // see R8
                    next_st.osr = {1'b0, st.osr[63:1]};
                end
                if (sel_fall) begin
                    next_st.ls = LS_RECV;
                    next_st.oe = 1'b0; // see R10
                    next_st.dout = 1'b0;
                end
            end
        endcase
        if (alert_clear) begin
            next_st.alert = 1'b0;
        end
        if (scan_done) begin
            next_st.alert = 1'b1;
        end
        if (key_change) begin
            next_st.run = 1'b1;
        end
        if (setup) begin
            next_st.pslverr = ~addr_mapped(paddr);
            next_st.prdata = 32'h00000000;
            unique case (paddr)
                vsc_pkg::ADDR_STATUS: begin
                    next_st.prdata[9:0] = st.duty;
                    next_st.prdata[vsc_pkg::ST_RUN] = st.run;
                    next_st.prdata[vsc_pkg::ST_ALERT] = st.alert;
                    next_st.prdata[vsc_pkg::ST_ARMED] = (st.ls == LS_ARMED);
                    next_st.prdata[vsc_pkg::ST_SEND] = (st.ls == LS_SEND);
                    next_st.prdata[vsc_pkg::ST_OE] = st.oe;
                end
                vsc_pkg::ADDR_CONFIG: begin
                    next_st.prdata[vsc_pkg::CFG_TRIPLEX] = st.triplex;
                end
                vsc_pkg::ADDR_PAT1: begin
                    next_st.prdata = st.pattern[0];
                end
                vsc_pkg::ADDR_PAT2: begin
                    next_st.prdata = st.pattern[1];
                end
                vsc_pkg::ADDR_PAT3: begin
                    next_st.prdata = st.pattern[2];
                end
                default: begin
                    next_st.prdata = 32'h00000000;
                end
            endcase
        end
        if (access && pwrite && paddr == vsc_pkg::ADDR_CONFIG) begin
            next_st.triplex = pwdata[vsc_pkg::CFG_TRIPLEX];
            if (pwdata[vsc_pkg::CFG_SCAN_START]) begin
                next_st.run = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0; // see R1
            st.duty <= vsc_pkg::DIM_RESET; // see R2
            st.ls <= LS_RECV;
            st.triplex <= vsc_pkg::CFG_TRIPLEX_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign disp.pattern = st.pattern;
    assign disp.duty = st.duty;
    assign disp.triplex = st.triplex;
    assign anode_outputs = disp.anode; // see R3
    assign cathode_drives = disp.cathode; // see R3
    assign keyscan_run = st.run;
    assign host_alert = st.alert; // see R3
    assign ser_data_out = st.dout;
    assign ser_data_oe = st.oe;
    assign prdata = st.prdata;
    assign pslverr = st.pslverr;
    assign pready = access;

endmodule : vsc_port

// file: test/vsc_host.sv
// Host model that drives the serial command link of the display port.
`timescale 1ns/1ps
module vsc_host (
    input wire logic clk,
    input wire logic ser_din,
    output logic ser_clk,
    output logic ser_sel,
    output logic ser_dq
);
    initial begin
        ser_clk = 1'b0;
        ser_sel = 1'b0;
        ser_dq = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // Sends n bits, bit 0 first, each set up half a period before its rise.
    task automatic shift(input logic [63:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            ser_dq <= v[i];
            tick(4);
            ser_clk <= 1'b1;
            tick(4);
            ser_clk <= 1'b0;
        end
    endtask : shift

    // The code follows the payload in one frame; the line then flips.
    task automatic frame(input logic [63:0] v, input int n);
        tick(1);
        ser_sel <= 1'b1;
        tick(4);
        shift(v, n);
        tick(4);
        ser_sel <= 1'b0;
        ser_dq <= ~ser_dq;
    endtask : frame

    // Reopens select after the readout code and clocks n bits in.
    task automatic read(input int n, output logic [63:0] q);
        q = '0;
        tick(1);
        ser_sel <= 1'b1;
        tick(4);
        for (int i = 0; i < n; i++) begin
            ser_clk <= 1'b1;
            tick(5);
            q[i] = ser_din;
            ser_clk <= 1'b0;
            tick(3);
        end
        ser_sel <= 1'b0;
    endtask : read
endmodule : vsc_host

// file: test/vsc_port_props.sv
// Concurrent checks on the pins of the serial command port.
`timescale 1ns/1ps
module vsc_port_props #(
    parameter int BIT_DIV = vsc_pkg::BIT_DIV
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ser_clk,
    input wire logic ser_sel,
    input wire logic ser_data_out,
    input wire logic ser_data_oe,
    input wire logic keyscan_run,
    input wire logic host_alert,
    input wire logic [31:0] anode_outputs,
    input wire logic [2:0] cathode_drives
);
    logic [7:0] since_rise;
    logic [7:0] since_fall;
    logic clk_q;
    logic sel_q;

    // Counts clocks since the last serial clock rise and select fall.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            since_rise <= 8'hff;
            since_fall <= 8'hff;
            clk_q <= 1'b0;
            sel_q <= 1'b0;
        end else begin
            clk_q <= ser_clk;
            sel_q <= ser_sel;
            since_rise <= (ser_clk && !clk_q) ? 8'h00 :
                since_rise + {7'h0, ~&since_rise};
            since_fall <= (!ser_sel && sel_q) ? 8'h00 :
                since_fall + {7'h0, ~&since_fall};
        end
    end

    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    AST_RESET_PINS: assert property ($rose(rst_b) |->
        !ser_data_out && !ser_data_oe && !keyscan_run)
        else $error("pins not cleared after reset");
    AST_RESET_DRIVE: assert property ($rose(rst_b) |->
        anode_outputs == 32'h0 && !host_alert &&
        cathode_drives == vsc_pkg::CATHODE_OFF)
        else $error("drivers not idle after reset");
    AST_DARK_START: assert property ($rose(rst_b) |->
        (cathode_drives == vsc_pkg::CATHODE_OFF) [*8])
        else $error("grid lit with zero duty");
    AST_OE_ON: assert property ($rose(ser_data_oe) |->
        !ser_sel && since_fall <= 8'd6)
        else $error("data pin turned without a closing select");
    AST_OE_OFF: assert property ($fell(ser_sel) && ser_data_oe |->
        ##[1:6] !ser_data_oe)
        else $error("data pin kept driving after select fell");
    AST_DOUT_QUIET: assert property (
        !ser_data_oe && !$past(ser_data_oe) |-> !ser_data_out)
        else $error("data output moved while released");
    AST_DOUT_EDGE: assert property (
        ser_sel && ser_data_oe && $changed(ser_data_out) |->
        since_rise <= 8'd6)
        else $error("readout bit changed away from a clock rise");
    AST_STOP_SEL: assert property ($fell(keyscan_run) |->
        since_fall <= 8'd6)
        else $error("key scan stopped without a frame end");
endmodule : vsc_port_props

bind vsc_port vsc_port_props #(.BIT_DIV(BIT_DIV)) i_props (
    .clk(clk), .rst_b(rst_b), .ser_clk(ser_clk), .ser_sel(ser_sel),
    .ser_data_out(ser_data_out), .ser_data_oe(ser_data_oe),
    .keyscan_run(keyscan_run), .host_alert(host_alert),
    .anode_outputs(anode_outputs), .cathode_drives(cathode_drives)
);

// file: test/vsc_port_tb.sv
// Self-checking bench for the serial command port.
`timescale 1ns/1ps
module vsc_port_tb;
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
    logic key_change, scan_done, ser_clk, ser_sel, h_dq;
    logic ser_data_out, ser_data_oe, keyscan_run, host_alert;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, anode, p, q;
    logic [31:0] pat [3];
    logic [24:0] keys;
    logic [2:0] kdir, cath;
    logic [8:0] kcnt;
    logic [63:0] adc, r, e;
    wire ser_pin;
    int seed = 58;
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0;
    int d;

    vsc_port #(.BIT_DIV(1)) i_dut (
        .clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ser_clk(ser_clk), .ser_sel(ser_sel), .ser_data_in(ser_pin),
        .ser_data_out(ser_data_out), .ser_data_oe(ser_data_oe),
        .key_matrix_bits(keys), .knob_direction_bit(kdir),
        .knob_count_bits(kcnt), .converter_result_bits(adc),
        .key_change(key_change), .scan_done(scan_done),
        .keyscan_run(keyscan_run), .host_alert(host_alert),
        .anode_outputs(anode), .cathode_drives(cath)
    );
    vsc_host i_host (
        .clk(clk), .ser_din(ser_pin), .ser_clk(ser_clk),
        .ser_sel(ser_sel), .ser_dq(h_dq)
    );
    // The pin shows the device's value while it drives, else the host's.
    assign ser_pin = ser_data_oe ? ser_data_out : h_dq;

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic report_and_stop();
        if (miscompares == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 45000) begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] w);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= w;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic pats();
        for (int g = 0; g < 3; g++) begin
            apb(1'b0, vsc_pkg::ADDR_PAT1 + 8'(4 * g), 32'h0);
            check(q, pat[g]);
        end
    endtask : pats

    // Counts lit grid cycles over one full scan and checks the anodes.
    task automatic lights(input int dv, input int ng);
        int n;
        n = 0;
        repeat (3072) @(posedge clk);
        repeat (1024 * ng) begin
            @(negedge clk);
            for (int g = 0; g < 3; g++) begin
                if (cath[g] === 1'b0) begin
                    n++;
                    check(anode, pat[g]);
                end
            end
        end
        check(n, ng * (dv > 1016 ? 1016 : dv));
    endtask : lights

    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        key_change = 1'b0;
        scan_done = 1'b0;
        keys = 25'($random(seed));
        kdir = 3'($random(seed));
        kcnt = 9'($random(seed));
        adc = {$random(seed), $random(seed)};
        for (int g = 0; g < 3; g++) pat[g] = 32'h0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        settle(4);
        check({cath, anode}, {vsc_pkg::CATHODE_OFF, 32'h0});
        check({keyscan_run, host_alert, ser_data_oe}, 3'h0);
        apb(1'b0, vsc_pkg::ADDR_STATUS, 32'h0);
        check(q[9:0], vsc_pkg::DIM_RESET);
        apb(1'b0, vsc_pkg::ADDR_CONFIG, 32'h0);
        check(q[0], vsc_pkg::CFG_TRIPLEX_RESET);
        apb(1'b0, 8'h20, 32'h0);
        check({err, q}, {1'b1, 32'h0});
        pats();
        lights(0, 3);
        for (int c = 0; c < 4; c++) begin
            p = $random(seed);
            if (c == 0) begin
                for (int g = 0; g < 3; g++) pat[g] = p;
            end else begin
                pat[c - 1] = p;
            end
            if (c % 2 == 1) begin
                i_host.frame({26'h0, 3'(c), p, 3'h5}, 38);
            end else begin
                i_host.frame({29'h0, 3'(c), p}, 35);
            end
            i_host.tick(8);
            pats();
        end
        i_host.shift({29'h0, 3'h1, ~pat[0]}, 35);
        i_host.tick(8);
        pats();
        for (int k = 0; k < 3; k++) begin
            d = (k == 0) ? ($random(seed) & 32'h3ff) : (k == 1) ? 64 : 1023;
            i_host.frame({51'h0, 3'h4, 10'(d)}, 13);
            lights(d, 3);
        end
        apb(1'b1, vsc_pkg::ADDR_CONFIG, 32'h0);
        apb(1'b0, vsc_pkg::ADDR_CONFIG, 32'h0);
        check(q[0], 1'b0);
        lights(d, 2);
        @(posedge clk);
        scan_done <= 1'b1;
        @(posedge clk);
        scan_done <= 1'b0;
        settle(2);
        check(host_alert, 1'b1);
        i_host.frame(64'h6, 3);
        settle(8);
        check({ser_data_oe, host_alert}, 2'b10);
        i_host.read(40, r);
        e = {27'h0, kcnt[8:6], kdir[2], kcnt[5:3], kdir[1], kcnt[2:0],
            kdir[0], keys};
        check(r, e);
        settle(8);
        check(ser_data_oe, 1'b0);
        i_host.frame(64'h7, 3);
        settle(8);
        i_host.read(64, r);
        check(r, adc);
        apb(1'b1, vsc_pkg::ADDR_CONFIG, 32'h3);
        settle(2);
        check(keyscan_run, 1'b1);
        i_host.frame(64'h5, 3);
        settle(8);
        check(keyscan_run, 1'b0);
        @(posedge clk);
        key_change <= 1'b1;
        @(posedge clk);
        key_change <= 1'b0;
        settle(3);
        check(keyscan_run, 1'b1);
        report_and_stop();
    end
endmodule : vsc_port_tb
